// ### logic/atf_regs.sv
// atf_regs: error, feature, count, address and drive/head task file regs.
// assumes ata strobes are synchronous to CLK_SYS and one cycle per access;
// the internal command engine reports completion and causes by pulses.
//
// Operation
// R1 - error causes meaningful only while status error bit is set
// R2 - error register read-only, resets zero; bits 5,3,1 read zero
// R3 - bit 4 set when requested sector id invalid or missing
// R4 - feature written by host only, passed to next command
// R5 - sector count is sectors to transfer; zero means 256
// R6 - successful completion leaves sector count at zero
// R7 - failed completion leaves count of sectors still outstanding
// R8 - sector number is chs start sector or lba bits 7-0
// R9 - cylinder low is cylinder bits 7-0 or lba 15-8
// R10 - cylinder high is cylinder high bits or lba 23-16
// R11 - drive/head bit 6 selects chs (0) or lba (1)
// R12 - in lba mode head bits 3-0 are lba bits 27-24
// R13 - in chs mode head bits 3-0 are head number
// R14 - drive/head bit 4 selects master (0) or slave (1)
// R15 - drive/head resets to a0h; bits 7 and 5 read one
// R16 - host reaches registers only via chip selects and a2-a0
// R17 - error register cleared when a new command is accepted
`timescale 1ns/1ps

module atf_regs
(
  // clock and reset
  input  wire logic              CLK_SYS,
  input  wire logic              RST,
  // ata host register port
  input  wire logic              COMMAND_BLOCK_SELECT_N,
  input  wire logic              CONTROL_BLOCK_SELECT_N,
  input  wire logic [2:0]        ADDR,
  input  wire logic              RD_STROBE,
  input  wire logic              WR_STROBE,
  input  wire logic [7:0]        WDATA,
  output logic      [7:0]        RDATA,
  output logic                   RDATA_VALID,
  // command engine side
  input  wire logic              CMD_ACCEPT,
  input  wire logic              CMD_DONE,
  input  wire logic              CMD_FAIL,
  input  wire logic [8:0]        SECTORS_LEFT,
  input  wire atf_pkg::atf_err_t ERR_SET,
  input  wire logic              STATUS_ERROR,
  output atf_pkg::atf_addr_t     CMD_ADDR,
  output logic      [7:0]        FEATURE
);

  // ==========================================================================
  // state
  atf_pkg::atf_state_t st_ff;
  atf_pkg::atf_state_t nxt_st;
  atf_pkg::atf_addr_t  addr_ff;
  atf_pkg::atf_addr_t  nxt_addr;
  logic                sel;
  logic [7:0]          dh;
  logic [7:0]          err_in;

  // ==========================================================================
  // next state
  always_comb
  begin
    nxt_st          = st_ff;
    nxt_st.rd_valid = 1'b0;
    // only command block with control block idle is ours
    sel = !COMMAND_BLOCK_SELECT_N && CONTROL_BLOCK_SELECT_N; // [R16]
    err_in = 8'h00;
    err_in[atf_pkg::ERR_BAD_BLOCK]  = ERR_SET.bad_block_flag;
    err_in[atf_pkg::ERR_UNCORR]     = ERR_SET.uncorrectable_flag;
    err_in[atf_pkg::ERR_ID_MISSING] = ERR_SET.sector_id_missing_flag; // [R3]
    err_in[atf_pkg::ERR_ABORTED]    = ERR_SET.command_aborted_flag;
    err_in[atf_pkg::ERR_GENERAL]    = ERR_SET.general_error_flag;

    // host writes first; engine updates below take precedence
    if (sel && WR_STROBE)
    begin
      if (ADDR == atf_pkg::ADR_ERR_FEAT)
        nxt_st.feature_select = WDATA; // [R4]
      else if (ADDR == atf_pkg::ADR_SECT_CNT)
        nxt_st.transfer_sector_count = WDATA;
      else if (ADDR == atf_pkg::ADR_SECT_NUM)
        nxt_st.start_sector_lba_low = WDATA;
      else if (ADDR == atf_pkg::ADR_CYL_LOW)
        nxt_st.cylinder_lba_mid = WDATA;
      else if (ADDR == atf_pkg::ADR_CYL_HIGH)
        nxt_st.cylinder_lba_high = WDATA;
      else if (ADDR == atf_pkg::ADR_DRV_HEAD)
        nxt_st.drive_head_select = WDATA | atf_pkg::DH_FIXED_ONE; // [R15]
    end

    // new command wipes stale causes; a cause in same cycle still lands
    if (CMD_ACCEPT)
      nxt_st.error_cause = atf_pkg::ERR_RESET; // [R17]
    nxt_st.error_cause = (nxt_st.error_cause | err_in)
                         & atf_pkg::ERR_MASK; // [R2]

    if (CMD_DONE)
    begin
      if (CMD_FAIL)
        nxt_st.transfer_sector_count = SECTORS_LEFT[7:0]; // [R7]
      else
        nxt_st.transfer_sector_count = 8'h00; // [R6]
    end

    // reads: error read-only; feature not readable at same address
    if (sel && RD_STROBE)
    begin
      nxt_st.rd_valid = 1'b1;
      if (ADDR == atf_pkg::ADR_ERR_FEAT)
        // causes only meaningful when status error is raised
        nxt_st.rd_data = STATUS_ERROR ? st_ff.error_cause
                                      : atf_pkg::ERR_RESET; // [R1]
      else if (ADDR == atf_pkg::ADR_SECT_CNT)
        nxt_st.rd_data = st_ff.transfer_sector_count;
      else if (ADDR == atf_pkg::ADR_SECT_NUM)
        nxt_st.rd_data = st_ff.start_sector_lba_low;
      else if (ADDR == atf_pkg::ADR_CYL_LOW)
        nxt_st.rd_data = st_ff.cylinder_lba_mid;
      else if (ADDR == atf_pkg::ADR_CYL_HIGH)
        nxt_st.rd_data = st_ff.cylinder_lba_high;
      else if (ADDR == atf_pkg::ADR_DRV_HEAD)
        nxt_st.rd_data = st_ff.drive_head_select | atf_pkg::DH_FIXED_ONE;
      else
      begin
        nxt_st.rd_data  = 8'h00;
        nxt_st.rd_valid = 1'b0;
      end
    end

    // decoded address view from the new register contents
    dh = nxt_st.drive_head_select;
    nxt_addr.lba_mode         = dh[atf_pkg::DH_LBA_MODE]; // [R11]
    nxt_addr.drive_select_bit = dh[atf_pkg::DH_DRIVE];    // [R14]
    nxt_addr.lba = {dh[3:0],                               // [R12]
                    nxt_st.cylinder_lba_high,              // [R10]
                    nxt_st.cylinder_lba_mid,               // [R9]
                    nxt_st.start_sector_lba_low};          // [R8]
    nxt_addr.cylinder = {nxt_st.cylinder_lba_high,
                         nxt_st.cylinder_lba_mid};         // [R9] [R10]
    nxt_addr.head   = dh[3:0];                             // [R13]
    nxt_addr.sector = nxt_st.start_sector_lba_low;         // [R8]
    nxt_addr.sectors = (nxt_st.transfer_sector_count == 8'h00)
                       ? atf_pkg::SECTORS_ZERO
                       : {1'b0, nxt_st.transfer_sector_count}; // [R5]
  end

  // ==========================================================================
  // registers
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      st_ff.error_cause           <= atf_pkg::ERR_RESET; // [R2]
      st_ff.feature_select        <= atf_pkg::REG_RESET;
      st_ff.transfer_sector_count <= atf_pkg::REG_RESET;
      st_ff.start_sector_lba_low  <= atf_pkg::REG_RESET;
      st_ff.cylinder_lba_mid      <= atf_pkg::REG_RESET;
      st_ff.cylinder_lba_high     <= atf_pkg::REG_RESET;
      st_ff.drive_head_select     <= atf_pkg::DH_RESET; // [R15]
      st_ff.rd_data               <= 8'h00;
      st_ff.rd_valid              <= 1'b0;
      addr_ff                     <= '0;
      addr_ff.sectors             <= atf_pkg::SECTORS_ZERO;
    end
    else
    begin
      st_ff   <= nxt_st;
      addr_ff <= nxt_addr;
    end
  end

  // ==========================================================================
  // outputs, all from flops
  assign RDATA       = st_ff.rd_data;
  assign RDATA_VALID = st_ff.rd_valid;
  assign FEATURE     = st_ff.feature_select; // [R4]
  assign CMD_ADDR    = addr_ff;

endmodule

// ### pkg/atf_pkg.sv
// atf_pkg: constants and carrier types for the task file register subset.
// assumes one system clock; ata strobes already synchronous to it.
package atf_pkg;

  // ==========================================================================
  // register addresses (a2..a0, command block select active)
  localparam logic [2:0] ADR_ERR_FEAT = 3'h1;
  localparam logic [2:0] ADR_SECT_CNT = 3'h2;
  localparam logic [2:0] ADR_SECT_NUM = 3'h3;
  localparam logic [2:0] ADR_CYL_LOW  = 3'h4;
  localparam logic [2:0] ADR_CYL_HIGH = 3'h5;
  localparam logic [2:0] ADR_DRV_HEAD = 3'h6;

  // ==========================================================================
  // field positions
  localparam int ERR_BAD_BLOCK   = 7;
  localparam int ERR_UNCORR      = 6;
  localparam int ERR_ID_MISSING  = 4;
  localparam int ERR_ABORTED     = 2;
  localparam int ERR_GENERAL     = 0;
  localparam int DH_LBA_MODE     = 6;
  localparam int DH_DRIVE        = 4;

  // ==========================================================================
  // reset values and masks
  localparam logic [7:0] ERR_RESET    = 8'h00;
  localparam logic [7:0] ERR_MASK     = 8'hD5;
  localparam logic [7:0] DH_RESET     = 8'hA0;
  localparam logic [7:0] DH_FIXED_ONE = 8'hA0;
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [8:0] SECTORS_ZERO = 9'h100;

  // ==========================================================================
  // error cause flags reported by the command engine
  typedef struct packed {
    logic bad_block_flag;
    logic uncorrectable_flag;
    logic sector_id_missing_flag;
    logic command_aborted_flag;
    logic general_error_flag;
  } atf_err_t;

  // decoded address presented to the command engine
  typedef struct packed {
    logic        lba_mode;
    logic        drive_select_bit;
    logic [27:0] lba;
    logic [15:0] cylinder;
    logic [3:0]  head;
    logic [7:0]  sector;
    logic [8:0]  sectors;
  } atf_addr_t;

  // whole register state
  typedef struct packed {
    logic [7:0] error_cause;
    logic [7:0] feature_select;
    logic [7:0] transfer_sector_count;
    logic [7:0] start_sector_lba_low;
    logic [7:0] cylinder_lba_mid;
    logic [7:0] cylinder_lba_high;
    logic [7:0] drive_head_select;
    logic [7:0] rd_data;
    logic       rd_valid;
  } atf_state_t;

endpackage

// ### testbench/atf_properties.sv
// atf_properties: concurrent checks on the task file register ports.
// assumes it is bound to atf_regs and sees only its ports.
`timescale 1ns/1ps
module atf_properties
(
  // clock, reset and host port
  input wire logic               CLK_SYS,
  input wire logic               RST,
  input wire logic               COMMAND_BLOCK_SELECT_N,
  input wire logic               CONTROL_BLOCK_SELECT_N,
  input wire logic [2:0]         ADDR,
  input wire logic               RD_STROBE,
  input wire logic               WR_STROBE,
  input wire logic [7:0]         WDATA,
  input wire logic [7:0]         RDATA,
  input wire logic               RDATA_VALID,
  // command engine side
  input wire logic               CMD_DONE,
  input wire logic               CMD_FAIL,
  input wire logic [8:0]         SECTORS_LEFT,
  input wire logic               STATUS_ERROR,
  input wire atf_pkg::atf_addr_t CMD_ADDR,
  input wire logic [7:0]         FEATURE
);
  // ==========================================================================
  // helpers
  logic       sel;
  logic [7:0] wdata_ff;
  logic [7:0] left_ff;
  assign sel = !COMMAND_BLOCK_SELECT_N && CONTROL_BLOCK_SELECT_N
               && ADDR inside {[3'h1:3'h6]};
  always_ff @(posedge CLK_SYS)
  begin
    wdata_ff <= WDATA;
    left_ff  <= SECTORS_LEFT[7:0];
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // ==========================================================================
  // properties
  chk_rd_answer: assert property
    (sel && RD_STROBE |=> RDATA_VALID) else $error("read not answered");
  chk_rd_refused: assert property
    (!(sel && RD_STROBE) |=> !RDATA_VALID) else $error("stray answer");
  chk_err_gated: assert property
    (sel && RD_STROBE && ADDR == atf_pkg::ADR_ERR_FEAT && !STATUS_ERROR
     |=> RDATA == 8'h00) else $error("error shown without status");
  chk_dh_ones: assert property
    (sel && RD_STROBE && ADDR == atf_pkg::ADR_DRV_HEAD
     |=> RDATA[7] && RDATA[5]) else $error("fixed ones lost");
  chk_dh_decode: assert property
    (sel && WR_STROBE && ADDR == atf_pkg::ADR_DRV_HEAD |=>
     CMD_ADDR.lba_mode == wdata_ff[6] && CMD_ADDR.drive_select_bit == wdata_ff[4]
     && (CMD_ADDR.lba_mode ? CMD_ADDR.lba[27:24] : CMD_ADDR.head)
        == wdata_ff[3:0]) else $error("drive/head decode wrong");
  chk_lba_bytes: assert property
    (sel && WR_STROBE && ADDR inside {[3'h3:3'h5]} |=>
     (ADDR == atf_pkg::ADR_SECT_NUM || $past(ADDR) != atf_pkg::ADR_SECT_NUM
      || (CMD_ADDR.lba[7:0] == wdata_ff && CMD_ADDR.sector == wdata_ff))
     && ($past(ADDR) != atf_pkg::ADR_CYL_LOW
      || (CMD_ADDR.lba[15:8] == wdata_ff
          && CMD_ADDR.cylinder[7:0] == wdata_ff))
     && ($past(ADDR) != atf_pkg::ADR_CYL_HIGH
      || (CMD_ADDR.lba[23:16] == wdata_ff
          && CMD_ADDR.cylinder[15:8] == wdata_ff)))
    else $error("address byte decode wrong");
  chk_feat_write: assert property
    (sel && WR_STROBE && ADDR == atf_pkg::ADR_ERR_FEAT
     |=> FEATURE == wdata_ff) else $error("feature not taken");
  chk_count_done: assert property
    (CMD_DONE && !CMD_FAIL |=> CMD_ADDR.sectors == atf_pkg::SECTORS_ZERO)
    else $error("count not cleared");
  chk_count_fail: assert property
    (CMD_DONE && CMD_FAIL && SECTORS_LEFT[7:0] != 8'h00
     |=> CMD_ADDR.sectors == {1'b0, left_ff}) else $error("count not left");
endmodule

// ### testbench/atf_host.sv
// atf_host: ata host model issuing one task file access per call.
// assumes the bench calls cyc; lines change on the falling edge only.
`timescale 1ns/1ps
module atf_host
(
  // clock
  input  wire logic       CLK_SYS,
  // ata register port
  output logic            COMMAND_BLOCK_SELECT_N,
  output logic            CONTROL_BLOCK_SELECT_N,
  output logic      [2:0] ADDR,
  output logic            RD_STROBE,
  output logic            WR_STROBE,
  output logic      [7:0] WDATA
);
  initial {COMMAND_BLOCK_SELECT_N, CONTROL_BLOCK_SELECT_N} = 2'b11;
  initial {ADDR, WDATA, RD_STROBE, WR_STROBE} = 13'h0000;
  task automatic cyc(input logic w, input logic [2:0] a,
                     input logic [7:0] d, input logic ctl);
    @(negedge CLK_SYS);
    {COMMAND_BLOCK_SELECT_N, CONTROL_BLOCK_SELECT_N} = {1'b0, ctl};
    {ADDR, WDATA, RD_STROBE, WR_STROBE} = {a, d, !w, w};
    @(negedge CLK_SYS);
    // inverse on release so a stale copy can never pass for data
    {COMMAND_BLOCK_SELECT_N, ADDR, WDATA} = {1'b1, ~a, ~d};
    {RD_STROBE, WR_STROBE} = 2'b00;
  endtask
endmodule

// ### testbench/testbench.sv
// testbench: host and engine driven checks of the task file registers.
// assumes atf_pkg, atf_regs, atf_host and atf_properties compiled first.
`timescale 1ns/1ps
module testbench;
  logic CLK_SYS = 1'b0;
  logic RST = 1'b1;
  logic COMMAND_BLOCK_SELECT_N, CONTROL_BLOCK_SELECT_N, RD_STROBE, WR_STROBE;
  logic [2:0] ADDR;
  logic [7:0] WDATA, RDATA, FEATURE, w;
  logic RDATA_VALID;
  logic CMD_ACCEPT = 1'b0, CMD_DONE = 1'b0, CMD_FAIL = 1'b0;
  logic STATUS_ERROR = 1'b1;
  logic [8:0] SECTORS_LEFT = 9'h000;
  atf_pkg::atf_err_t ERR_SET = 5'h00;
  atf_pkg::atf_addr_t CMD_ADDR;
  int n_fail = 0;
  int samples_checked = 0;
  int pos [5] = '{0, 2, 4, 6, 7};
  logic [7:0] exp_q [$];
  logic [31:0] seed = 32'h185a;
  atf_regs uut (.*);
  atf_host host (.*);
  always #4 CLK_SYS = ~CLK_SYS;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [49:0] seen, input logic [49:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (n_fail == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.cyc(1'b0, a, 8'h00, 1'b1);
  endtask
  task automatic engine(input logic acc, done, fail, input logic [4:0] err);
    @(negedge CLK_SYS);
    {CMD_ACCEPT, CMD_DONE, CMD_FAIL, ERR_SET} = {acc, done, fail, err};
    @(negedge CLK_SYS);
    {CMD_ACCEPT, CMD_DONE, CMD_FAIL, ERR_SET} = 8'h00;
  endtask
  // every answer pops the oldest note; an answer nobody asked for fails
  always @(negedge CLK_SYS)
    if (RDATA_VALID === 1'b1)
      check(RDATA, exp_q.size() ? exp_q.pop_front() : ~RDATA);
  initial
  begin
    #20000;
    n_fail++;
    end_of_test();
  end
  initial
  begin
    repeat (6) @(posedge CLK_SYS);
    @(negedge CLK_SYS) RST = 1'b0;
    rd(3'h1, 8'h00);
    rd(3'h6, atf_pkg::DH_RESET);
    for (int a = 2; a < 6; a++) rd(3'(a), 8'h00);
    for (int i = 0; i < 12; i++)
    begin
      seed = lfsr(seed);
      w = seed[7:0];
      host.cyc(1'b1, 3'(2 + i % 5), w, 1'b1);
      rd(3'(2 + i % 5), (i % 5 == 4) ? w | 8'hA0 : w);
    end
    host.cyc(1'b1, 3'h1, 8'h5A, 1'b1);
    rd(3'h1, 8'h00);
    check(FEATURE, 8'h5A);
    host.cyc(1'b0, 3'h0, 8'h00, 1'b1);
    host.cyc(1'b0, 3'h7, 8'h00, 1'b1);
    host.cyc(1'b0, 3'h1, 8'h00, 1'b0);
    // accept and a new cause in one cycle: only the new cause survives
    for (int i = 0; i < 5; i++)
    begin
      engine(1'b1, 1'b0, 1'b0, 5'(1 << i));
      rd(3'h1, 8'h01 << pos[i]);
    end
    engine(1'b0, 1'b0, 1'b0, 5'h1F);
    rd(3'h1, atf_pkg::ERR_MASK);
    STATUS_ERROR = 1'b0;
    rd(3'h1, 8'h00);
    host.cyc(1'b1, 3'h2, 8'h10, 1'b1);
    SECTORS_LEFT = 9'h005;
    engine(1'b0, 1'b1, 1'b1, 5'h00);
    rd(3'h2, 8'h05);
    engine(1'b0, 1'b1, 1'b0, 5'h00);
    rd(3'h2, 8'h00);
    check(CMD_ADDR.sectors, atf_pkg::SECTORS_ZERO);
    repeat (3) @(negedge CLK_SYS);
    check(exp_q.size(), 0);
    end_of_test();
  end
endmodule
bind atf_regs atf_properties chk (.*);
